// file: hdl/scce_pkg.sv
/*
  shared constants and types for the screen contamination evaluator:
  register map, field positions, reset values, strategy codes, sector layout.
  assumes a 32-bit apb register bus and six screen sectors.
*/
package scce_pkg;

  // sector layout
  localparam int unsigned SECTOR_COUNT = 6;
  localparam int unsigned GROUP_SIZE = 3;
  localparam int unsigned COUNT_W = 3;

  // apb register byte addresses
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] SECTOR_ADDR = 12'h008;

  // field positions
  localparam int unsigned STRAT_LSB = 0;
  localparam int unsigned STRAT_W = 3;
  localparam int unsigned STATUS_WARN_BIT = 0;
  localparam int unsigned STATUS_ERR_BIT = 1;
  localparam int unsigned SECT_WARN_LSB = 0;
  localparam int unsigned SECT_ERR_LSB = 8;

  // evaluation strategies, code order is the register encoding
  typedef enum logic [2:0] {
    strat_off,
    strat_high_avail,
    strat_avail,
    strat_semi,
    strat_sensitive
  } scce_strategy_type;

  // semi-sensitive thresholds
  localparam logic [COUNT_W-1:0] SEMI_ERR_ONE = 3'h1;
  localparam logic [COUNT_W-1:0] SEMI_ERR_MANY = 3'h2;
  localparam logic [COUNT_W-1:0] SEMI_WARN_MANY = 3'h2;

  // reset values
  localparam scce_strategy_type STRAT_RESET = strat_off;
  localparam logic [SECTOR_COUNT-1:0] SECTOR_RESET = 6'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // per-sector limit flags as one bundle
  typedef struct packed {
    logic [SECTOR_COUNT-1:0] err;
    logic [SECTOR_COUNT-1:0] warn;
  } scce_sector_type;

  // combined result
  typedef struct packed {
    logic err;
    logic warn;
  } scce_result_type;

endpackage : scce_pkg

// file: hdl/scce_evaluator.sv
/*
  screen contamination evaluator: synchronises the six-sector warning and
  error limit flags, combines them by the selected strategy into one
  contamination warning and one error, drives the status indicators and
  offers strategy, result and sector state over an apb slave.
  assumes: sector flags come asynchronously from a separate measurement
  front end; the apb master runs on pclk.
*/
// Implementation choices: the address map and the APB register port.

// How it works
// (R1) evaluate continuously from dedicated sector flags
// (R2) warning limit lower than error limit
// (R3) deactivated strategy keeps both flags low
// (R4) high availability needs all six sectors
// (R5) available: all three of either half
// (R6) semi: no errors, <=1 warning, nothing
// (R7) semi: one error, >=2 warnings, warning
// (R8) semi: two or more errors, error
// (R9) sensitive: any single sector suffices
// (R10) results drive the status indicator outputs
// (R11) other semi combinations give warning only
`timescale 1ns/1ps

module scce_evaluator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] sector_warn_in,
  input wire logic [5:0] sector_err_in,
  output logic contamination_warn,
  output logic contamination_err,
  output logic status_warn_led,
  output logic status_err_led
);

  localparam int unsigned SYNC_W = 2 * scce_pkg::SECTOR_COUNT;

  // count the sectors whose flag is set
  function automatic logic [scce_pkg::COUNT_W-1:0] count_set(
    input logic [scce_pkg::SECTOR_COUNT-1:0] v
  );
    logic [scce_pkg::COUNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < scce_pkg::SECTOR_COUNT; i++)
    begin
      n = n + {{(scce_pkg::COUNT_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction : count_set

  // either half of the screen fully at its limit
  function automatic logic half_full(
    input logic [scce_pkg::SECTOR_COUNT-1:0] v
  );
    logic right_full;
    logic left_full;
    right_full = &v[scce_pkg::GROUP_SIZE-1:0];
    left_full = &v[scce_pkg::SECTOR_COUNT-1:scce_pkg::GROUP_SIZE];
    return right_full | left_full;
  endfunction : half_full

  // one-hot register select: bit 0 control, bit 1 status, bit 2 sectors;
  // an unmapped address gives all zeros and is answered with pslverr;
  // kept as a function so the bus answer and the read side decode alike
  function automatic logic [2:0] decode_addr(
    input logic [scce_pkg::ADDR_W-1:0] a
  );
    logic [2:0] sel;
    sel = 3'h0;
    if (a == scce_pkg::CTRL_ADDR)
    begin
      sel = 3'h1;
    end
    else if (a == scce_pkg::STATUS_ADDR)
    begin
      sel = 3'h2;
    end
    else if (a == scce_pkg::SECTOR_ADDR)
    begin
      sel = 3'h4;
    end
    else
    begin
      sel = 3'h0;
    end
    return sel;
  endfunction : decode_addr

  // ---------------------------------------------------------------
  // sector input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] stable_q;
  logic [SYNC_W-1:0] stable_d;

  assign raw_in = {sector_err_in, sector_warn_in};

  // three stages per bit; a change counts once stages two and three agree,
  // which also rejects a single-cycle glitch from the front end
  // limitation: a change held for fewer than two cycles may be lost
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : g_sync
      assign stable_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : stable_q[g];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          stable_q[g] <= 1'b0;
        end
        else if (ce)
        begin
          sync1_q[g] <= raw_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          stable_q[g] <= stable_d[g];
        end
      end
    end
  endgenerate

  // cleaned sector flags, used by the evaluation and readable by software
  scce_pkg::scce_sector_type sectors;

  assign sectors.warn = stable_q[scce_pkg::SECTOR_COUNT-1:0]; // [R1]
  assign sectors.err = stable_q[SYNC_W-1:scce_pkg::SECTOR_COUNT]; // [R1]

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  scce_pkg::scce_strategy_type strategy_q;
  scce_pkg::scce_strategy_type strategy_d;
  scce_pkg::scce_result_type result_q;
  scce_pkg::scce_result_type result_d;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic pready_q;
  logic pslverr_q;
  logic addr_hit;
  logic access;
  logic complete;
  logic wr_ctrl;
  logic code_valid;
  logic [scce_pkg::STRAT_W-1:0] wr_code;
  logic [2:0] reg_sel;
  logic sel_ctrl;
  logic sel_status;
  logic sel_sector;
  logic warn_led_q;
  logic err_led_q;

  // one wait state: pready rises in the cycle after the access phase opens,
  // so read data and the error answer can come from flip-flops
  assign access = psel & penable & ~pready_q;
  assign complete = psel & penable & pready_q;

  // address decode; writes to the read-only registers are ignored quietly
  assign reg_sel = decode_addr(paddr);
  assign sel_ctrl = reg_sel[0];
  assign sel_status = reg_sel[1];
  assign sel_sector = reg_sel[2];
  assign addr_hit = |reg_sel;

  // codes past the last strategy are dropped so the setting stays meaningful
  assign wr_code = pwdata[scce_pkg::STRAT_LSB +: scce_pkg::STRAT_W];
  assign code_valid = (wr_code <= scce_pkg::STRAT_W'(scce_pkg::strat_sensitive));
  assign wr_ctrl = complete & pwrite & pstrb[0] & code_valid &
                   sel_ctrl;

  // read multiplexer
  always_comb
  begin
    rdata_d = '0;
    if (sel_ctrl)
    begin
      rdata_d[scce_pkg::STRAT_LSB +: scce_pkg::STRAT_W] = strategy_q;
    end
    else if (sel_status)
    begin
      rdata_d[scce_pkg::STATUS_WARN_BIT] = result_q.warn;
      rdata_d[scce_pkg::STATUS_ERR_BIT] = result_q.err;
    end
    else if (sel_sector)
    begin
      rdata_d[scce_pkg::SECT_WARN_LSB +: scce_pkg::SECTOR_COUNT] = sectors.warn;
      rdata_d[scce_pkg::SECT_ERR_LSB +: scce_pkg::SECTOR_COUNT] = sectors.err;
    end
    else
    begin
      rdata_d = '0;
    end
  end

  // strategy register takes a write at the completing edge only
  assign strategy_d = wr_ctrl ? scce_pkg::scce_strategy_type'(wr_code) : strategy_q;

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= scce_pkg::RDATA_RESET;
    end
    else if (ce)
    begin
      pready_q <= access;
      pslverr_q <= access & ~addr_hit; // unmapped address
      prdata_q <= access ? rdata_d : scce_pkg::RDATA_RESET;
    end
  end

  // strategy register, kept apart so each flop process stays short
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strategy_q <= scce_pkg::STRAT_RESET;
    end
    else if (ce)
    begin
      strategy_q <= strategy_d;
    end
  end

  // answer outputs come straight from their flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // contamination evaluation
  // ---------------------------------------------------------------
  logic [scce_pkg::COUNT_W-1:0] warn_cnt;
  logic [scce_pkg::COUNT_W-1:0] err_cnt;
  logic semi_quiet;
  logic semi_warn;
  logic semi_err;

  // limitation: a pin change reaches the result flops five edges later
  assign warn_cnt = count_set(sectors.warn);
  assign err_cnt = count_set(sectors.err);

  // semi-sensitive cases, error has priority over the warning cases
  assign semi_err = (err_cnt >= scce_pkg::SEMI_ERR_MANY); // [R8]
  assign semi_quiet = (err_cnt == '0) &
                      (warn_cnt < scce_pkg::SEMI_WARN_MANY); // [R6]
  // one error with many warnings, plus every leftover combination
  assign semi_warn = ((err_cnt == scce_pkg::SEMI_ERR_ONE) &
                      (warn_cnt >= scce_pkg::SEMI_WARN_MANY)) | // [R7]
                     (~semi_err & ~semi_quiet); // [R11]

  // warning and error each test their own limit flags; the front end sets
  // the warning limit at a lower contamination, so warning shows first
  always_comb
  begin
    result_d = '0;
    case (strategy_q)
      scce_pkg::strat_off:
      begin
        result_d = '0; // [R3]
      end
      scce_pkg::strat_high_avail:
      begin
        result_d.warn = &sectors.warn; // [R4]
        result_d.err = &sectors.err; // [R4]
      end
      scce_pkg::strat_avail:
      begin
        result_d.warn = half_full(sectors.warn); // [R5]
        result_d.err = half_full(sectors.err); // [R5]
      end
      scce_pkg::strat_semi:
      begin
        result_d.warn = semi_warn & ~semi_err; // [R7]
        result_d.err = semi_err; // [R8]
      end
      scce_pkg::strat_sensitive:
      begin
        result_d.warn = |sectors.warn; // [R9]
        result_d.err = |sectors.err; // [R9]
      end
      default:
      begin
        result_d = '0;
      end
    endcase
  end

  // result register, refreshed every enabled cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q <= '0;
    end
    else if (ce)
    begin
      result_q <= result_d; // [R1] [R2]
    end
  end

  // indicator flops load the same next value as the result flops; a copy of
  // their own keeps every output on a flip-flop and lets the pins sit apart
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      warn_led_q <= 1'b0;
      err_led_q <= 1'b0;
    end
    else if (ce)
    begin
      warn_led_q <= result_d.warn; // [R10]
      err_led_q <= result_d.err; // [R10]
    end
  end

  // result outputs and indicators
  assign contamination_warn = result_q.warn;
  assign contamination_err = result_q.err;
  assign status_warn_led = warn_led_q; // [R10]
  assign status_err_led = err_led_q; // [R10]

endmodule : scce_evaluator

// file: dv/scce_front_end.sv
/*
  six-sector measurement front end model: limit flags as levels.
  assumes the bench commands the flags it wants.
*/
`timescale 1ns/1ps
module scce_front_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] want_warn,
  input wire logic [5:0] want_err,
  output logic [5:0] sector_warn_in,
  output logic [5:0] sector_err_in
);
  // flags move only after an edge and hold until told otherwise
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {sector_err_in, sector_warn_in} <= 12'h000;
    else {sector_err_in, sector_warn_in} <= {want_err, want_warn};
endmodule : scce_front_end

// file: dv/scce_props.sv
/*
  checker: flags against strategy and settled sector flags.
  assumes it is bound to the evaluator top.
*/
`timescale 1ns/1ps
module scce_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] sector_warn_in,
  input wire logic [5:0] sector_err_in,
  input wire logic contamination_warn,
  input wire logic contamination_err,
  input wire logic status_warn_led,
  input wire logic status_err_led
);
  logic [2:0] st_q;
  logic [11:0] in_q;
  logic [2:0] cnt_q;
  wire [2:0] wc = 3'($countones(sector_warn_in));
  wire [2:0] ec = 3'($countones(sector_err_in));
  wire wr = psel & penable & pready & pwrite & ce & (paddr == scce_pkg::CTRL_ADDR) & pstrb[0] & (pwdata[2:0] <= 3'h4);
  wire chg = wr | !ce | (in_q != {sector_err_in, sector_warn_in});
  wire ok = cnt_q == 3'h6;
  wire w = contamination_warn;
  wire e = contamination_err;
  // shadow strategy and settle count; 6 quiet edges cover the 5-edge input path
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) st_q <= 3'h0;
    else if (wr) st_q <= pwdata[2:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) in_q <= 12'h000;
    else in_q <= {sector_err_in, sector_warn_in};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_q <= 3'h0;
    else if (chg) cnt_q <= 3'h0;
    else if (!ok) cnt_q <= cnt_q + 3'h1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_off; ok && st_q == 3'h0 |-> !w && !e; endproperty
  a_off: assert property (p_off) else $error("flag raised while off");
  property p_to_off; wr && pwdata[2:0] == 3'h0 |=> ##1 !w && !e; endproperty
  a_to_off: assert property (p_to_off) else $error("flag kept after switch off");
  property p_high; ok && st_q == 3'h1 |-> w == &sector_warn_in && e == &sector_err_in; endproperty
  a_high: assert property (p_high) else $error("high availability flags wrong");
  property p_avail;
    ok && st_q == 3'h2 |-> w == (&sector_warn_in[2:0] | &sector_warn_in[5:3])
      && e == (&sector_err_in[2:0] | &sector_err_in[5:3]);
  endproperty
  a_avail: assert property (p_avail) else $error("available flags wrong");
  property p_none; ok && st_q == 3'h3 && ec == 3'h0 && wc <= 3'h1 |-> !w && !e; endproperty
  a_none: assert property (p_none) else $error("semi flags not clear");
  property p_warn; ok && st_q == 3'h3 && ec == 3'h1 && wc >= 3'h2 |-> w && !e; endproperty
  a_warn: assert property (p_warn) else $error("semi warning missing");
  property p_err; ok && st_q == 3'h3 && ec >= 3'h2 |-> e && !w; endproperty
  a_err: assert property (p_err) else $error("semi error missing");
  property p_rest; ok && st_q == 3'h3 && ec <= 3'h1 && (ec == 3'h0) == (wc >= 3'h2) |-> w && !e; endproperty
  a_rest: assert property (p_rest) else $error("semi other case wrong");
  property p_sens; ok && st_q == 3'h4 |-> w == |sector_warn_in && e == |sector_err_in; endproperty
  a_sens: assert property (p_sens) else $error("sensitive flags wrong");
  property p_led; status_warn_led == w && status_err_led == e; endproperty
  a_led: assert property (p_led) else $error("indicator differs from flag");
  c_semi: cover property (ok && st_q == 3'h3 && e);
  c_avail: cover property (ok && st_q == 3'h2 && w);
  c_bad: cover property (pready && pslverr);
endmodule : scce_props

bind scce_evaluator scce_props scce_props_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .sector_warn_in(sector_warn_in), .sector_err_in(sector_err_in),
  .contamination_warn(contamination_warn), .contamination_err(contamination_err),
  .status_warn_led(status_warn_led), .status_err_led(status_err_led));

// file: dv/scce_evaluator_bench.sv
/*
  bench: strategy table through apb, then reset and refusal cases.
  assumes the front end model drives the sector flags.
*/
`timescale 1ns/1ps
module scce_evaluator_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic [5:0] want_warn = 6'h00, want_err = 6'h00, sw, se;
  logic pready, pslverr, er, cw, cx, lw, lx;
  int num_errors = 0;
  int n_tests = 0;
  // table rows: strategy, flags in, warning and error out
  logic [2:0] r_s [13] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h3};
  logic [5:0] r_w [13] = '{6'h3f, 6'h3f, 6'h3e, 6'h07, 6'h16, 6'h01, 6'h03, 6'h00, 6'h0c, 6'h01, 6'h20, 6'h00, 6'h3f};
  logic [5:0] r_e [13] = '{6'h3f, 6'h1f, 6'h3f, 6'h38, 6'h1b, 6'h00, 6'h01, 6'h05, 6'h00, 6'h02, 6'h00, 6'h04, 6'h3f};
  logic r_ew [13] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic r_ee [13] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  // ce stays high except in the freeze test
  scce_evaluator scce_evaluator_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sector_warn_in(sw), .sector_err_in(se), .contamination_warn(cw),
    .contamination_err(cx), .status_warn_led(lw), .status_err_led(lx));
  scce_front_end scce_front_end_inst (.pclk(pclk), .presetn(presetn), .want_warn(want_warn),
    .want_err(want_err), .sector_warn_in(sw), .sector_err_in(se));
  always #50 pclk = ~pclk;
  task automatic results;
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, scce_pkg::CTRL_ADDR, 32'h0, 4'hf);
    chk("ctrl reset", 32'h0, rd);
    for (int i = 0; i < 13; i++)
    begin
      apb(1'b1, scce_pkg::CTRL_ADDR, {29'h0, r_s[i]}, 4'hf);
      want_warn <= r_w[i];
      want_err <= r_e[i];
      // five edges from the model's flop to the result flops, plus margin
      repeat (8) @(posedge pclk);
      chk("flags", {30'h0, r_ew[i], r_ee[i]}, {30'h0, cw, cx});
      chk("leds", {30'h0, r_ew[i], r_ee[i]}, {30'h0, lw, lx});
      apb(1'b0, scce_pkg::STATUS_ADDR, 32'h0, 4'hf);
      chk("status", {30'h0, r_ee[i], r_ew[i]}, rd);
      apb(1'b0, scce_pkg::SECTOR_ADDR, 32'h0, 4'hf);
      chk("sectors", {18'h0, r_e[i], 2'h0, r_w[i]}, rd);
    end
    // refused writes leave semi-sensitive in force
    apb(1'b1, scce_pkg::CTRL_ADDR, 32'h5, 4'hf);
    apb(1'b1, scce_pkg::CTRL_ADDR, 32'h0, 4'h0);
    repeat (2) @(posedge pclk);
    chk("err kept", 32'h1, {31'h0, cx});
    apb(1'b0, 12'h00c, 32'h0, 4'hf);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    // a low enable freezes every evaluator flop: the error holds while its flags clear
    ce <= 1'b0;
    want_err <= 6'h00;
    repeat (8) @(posedge pclk);
    chk("frozen flags", 32'h1, {30'h0, cw, cx});
    ce <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("thawed flags", 32'h2, {30'h0, cw, cx});
    // reset mid-run with flags present
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("flags after reset", 32'h0, {30'h0, cw, cx});
    apb(1'b1, scce_pkg::CTRL_ADDR, 32'h4, 4'h1);
    repeat (2) @(posedge pclk);
    chk("sensitive after reset", 32'h2, {30'h0, cw, cx});
    apb(1'b1, scce_pkg::CTRL_ADDR, 32'h0, 4'h1);
    repeat (2) @(posedge pclk);
    chk("switched off", 32'h0, {30'h0, cw, cx});
    results();
  end
  // watchdog, about ten times the expected run
  initial
  begin
    #400000;
    num_errors++;
    results();
  end
endmodule : scce_evaluator_bench
